/* rre_pkg.sv */
package rre_pkg;

	// opcode patterns
	localparam logic [14:0] RET_IRQ_HI = 15'h0008;
	localparam logic [14:0] RET_SUB_HI = 15'h0009;
	localparam logic [7:0] RET_LIT_HI = 8'h0c;
	localparam logic [5:0] ROT_HI = 6'h0d;
	localparam int S_BIT = 0;
	localparam int D_BIT = 9;
	localparam int A_BIT = 8;
	localparam logic [7:0] ILO_MAX = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

	// flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 4;

	// reset values
	localparam logic [7:0] W_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [3:0] BSR_RST = 4'h0;
	localparam logic [20:0] PC_RST = 21'h000000;

	typedef enum logic [1:0] {
		RRE_Q1 = 2'b00,
		RRE_Q2 = 2'b01,
		RRE_Q3 = 2'b11,
		RRE_Q4 = 2'b10
	} rre_phase_t;

	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} rre_mem_wr_t;

endpackage : rre_pkg

/* rre_phase_gen.sv */
`timescale 1ns/100ps
// quarter-phase sequencer, one 2-bit gray-coded phase output
module rre_phase_gen (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	output rre_pkg::rre_phase_t o_phase
);
	rre_pkg::rre_phase_t phase_q;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase_q <= rre_pkg::RRE_Q1;
		end else begin
			case (phase_q)
				rre_pkg::RRE_Q1: phase_q <= rre_pkg::RRE_Q2;
				rre_pkg::RRE_Q2: phase_q <= rre_pkg::RRE_Q3;
				rre_pkg::RRE_Q3: phase_q <= rre_pkg::RRE_Q4;
				rre_pkg::RRE_Q4: phase_q <= rre_pkg::RRE_Q1;
				default: phase_q <= rre_pkg::RRE_Q1;
			endcase
		end
	end

	assign o_phase = phase_q;

endmodule : rre_phase_gen

/* rre_exec.sv */
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
// What this block does
// RQ1: irq return pops stack into pc
// RQ2: irq return sets high or low enable
// RQ3: irq return leaves arithmetic flags alone
// RQ4: s=1 restores working, flags, bank shadows
// RQ5: s=0 keeps working, flags, bank
// RQ6: literal return loads literal into working
// RQ7: literal return pops stack into pc
// RQ8: returns leave pc latches untouched
// RQ9: subroutine return pops stack, no flags
// RQ10: rotate left through carry, update c,n,z
// RQ11: d selects working or file destination
// RQ12: a selects access bank or bank select
// RQ13: extended set, a=0, f<=95: indexed offset
// RQ14: returns take two cycles, pop in q4
// RQ15: rotate reads q2, computes q3, writes q4
module rre_exec (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [15:0] i_instr,
	input wire logic i_instr_valid,
	input wire logic [20:0] i_stack_top,
	input wire logic i_ext_set_en,
	input wire logic i_irq_prio_en,
	input wire logic [7:0] i_fsr2_base,
	input wire logic [7:0] i_mem_rdata,
	input wire logic [7:0] i_working_shadow,
	input wire logic [7:0] i_flags_shadow,
	input wire logic [3:0] i_bank_select_shadow,
	input wire logic [7:0] i_pc_high_latch,
	input wire logic [7:0] i_pc_upper_latch,
	output logic o_stack_pop,
	output logic [20:0] o_pc,
	output logic o_pc_load,
	output logic [7:0] o_working,
	output logic [7:0] o_flags,
	output logic [3:0] o_bank_select_reg,
	output logic o_high_prio_irq_enable,
	output logic o_low_prio_irq_enable,
	output logic [11:0] o_mem_addr,
	output logic o_mem_rd,
	output rre_pkg::rre_mem_wr_t o_mem_wr,
	output logic [7:0] o_pc_high_latch,
	output logic [7:0] o_pc_upper_latch,
	output logic o_busy
);
	logic rst_s1_q;
	logic rst_n;
	rre_pkg::rre_phase_t phase;

	// reset release through two flops
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// quarter phase sequencer
	rre_phase_gen u_phase (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.o_phase(phase)
	);

	// decode latched at q1
	logic [15:0] ir_q;
	logic live_q;
	logic nop_cycle_q;

	// architectural state
	logic [7:0] working_q;
	logic [7:0] flags_q;
	logic [3:0] bsr_q;
	logic high_prio_irq_enable_q;
	logic low_prio_irq_enable_q;
	logic [20:0] pc_q;
	logic pc_load_q;
	logic pop_q;

	// rotate pipeline
	logic [7:0] opnd_q;
	logic [7:0] res_q;
	logic res_c_q;

	// bus-side registers
	rre_pkg::rre_mem_wr_t wr_q;
	logic rd_q;
	logic [11:0] addr_q;
	logic [7:0] pch_q;
	logic [7:0] pcu_q;

	// decoded opcode classes
	logic is_irq_ret;
	logic is_sub_ret;
	logic is_lit_ret;
	logic is_rot;
	logic is_ret;
	logic shadow;
	logic [11:0] faddr;
	logic [7:0] f8;
	logic [7:0] next_f8;
	logic [7:0] rot_d;

	assign is_irq_ret = live_q && (ir_q[15:1] == rre_pkg::RET_IRQ_HI); // RQ1
	assign is_sub_ret = live_q && (ir_q[15:1] == rre_pkg::RET_SUB_HI); // RQ9
	assign is_lit_ret = live_q && (ir_q[15:8] == rre_pkg::RET_LIT_HI); // RQ6
	assign is_rot = live_q && (ir_q[15:10] == rre_pkg::ROT_HI); // RQ10
	assign is_ret = is_irq_ret || is_sub_ret || is_lit_ret;
	assign shadow = (is_irq_ret || is_sub_ret) && ir_q[rre_pkg::S_BIT]; // RQ4 RQ5
	assign f8 = ir_q[7:0];
	assign next_f8 = i_instr[7:0];

	// file address resolution from the incoming opcode
	always_comb begin
		if (i_instr[rre_pkg::A_BIT]) begin
			faddr = {bsr_q, next_f8}; // RQ12
		end else if (i_ext_set_en && (next_f8 <= rre_pkg::ILO_MAX)) begin
			faddr = {4'h0, 8'(i_fsr2_base + next_f8)}; // RQ13
		end else if (next_f8 >= rre_pkg::ACCESS_SPLIT) begin
			faddr = {rre_pkg::ACCESS_HI_BANK, next_f8}; // RQ12
		end else begin
			faddr = {4'h0, next_f8}; // RQ12
		end
	end

	// instruction capture; second return cycle is a no-op
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			ir_q <= 16'h0000;
			live_q <= 1'b0;
			nop_cycle_q <= 1'b0;
		end else if (phase == rre_pkg::RRE_Q1) begin
			if (nop_cycle_q) begin
				live_q <= 1'b0; // RQ14
			end else begin
				ir_q <= i_instr;
				live_q <= i_instr_valid;
			end
		end else if (phase == rre_pkg::RRE_Q4) begin
			nop_cycle_q <= is_ret; // RQ14
		end
	end

	// file address latched at decode, held for the cycle
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 12'h000;
		end else if ((phase == rre_pkg::RRE_Q1) && !nop_cycle_q) begin
			addr_q <= faddr; // RQ12 RQ13
		end
	end

	// rotate through carry, one slice per bit
	assign rot_d[0] = flags_q[rre_pkg::FLAG_C]; // RQ10
	for (genvar gi = 1; gi < 8; gi++) begin : g_rot
		assign rot_d[gi] = opnd_q[gi - 1]; // RQ10
	end

	// rotate datapath
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			opnd_q <= 8'h00;
			res_q <= 8'h00;
			res_c_q <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			rd_q <= 1'b0;
			case (phase)
				rre_pkg::RRE_Q1: rd_q <= 1'b0;
				rre_pkg::RRE_Q2: begin
					rd_q <= is_rot;
					opnd_q <= i_mem_rdata; // RQ15
				end
				rre_pkg::RRE_Q3: begin
					res_q <= rot_d; // RQ10
					res_c_q <= opnd_q[7]; // RQ10
				end
				rre_pkg::RRE_Q4: rd_q <= 1'b0;
				default: rd_q <= 1'b0;
			endcase
		end
	end

	// memory write in q4
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
		end else begin
			wr_q.we <= (phase == rre_pkg::RRE_Q4) && is_rot && ir_q[rre_pkg::D_BIT]; // RQ11 RQ15
			wr_q.addr <= addr_q; // RQ12
			wr_q.data <= res_q;
		end
	end

	// working register
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			working_q <= rre_pkg::W_RST;
		end else if (phase == rre_pkg::RRE_Q4) begin
			if (is_lit_ret) begin
				working_q <= f8; // RQ6
			end else if (shadow) begin
				working_q <= i_working_shadow; // RQ4
			end else if (is_rot && !ir_q[rre_pkg::D_BIT]) begin
				working_q <= res_q; // RQ11
			end
		end
	end

	// status flags
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= rre_pkg::FLAGS_RST;
		end else if (phase == rre_pkg::RRE_Q4) begin
			if (shadow) begin
				flags_q <= i_flags_shadow; // RQ4
			end else if (is_rot) begin
				flags_q[rre_pkg::FLAG_C] <= res_c_q; // RQ10
				flags_q[rre_pkg::FLAG_N] <= res_q[7]; // RQ10
				flags_q[rre_pkg::FLAG_Z] <= (res_q == 8'h00); // RQ10
			end
		end
	end

	// bank select
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			bsr_q <= rre_pkg::BSR_RST;
		end else if ((phase == rre_pkg::RRE_Q4) && shadow) begin
			bsr_q <= i_bank_select_shadow; // RQ4
		end
	end

	// global interrupt enables
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			high_prio_irq_enable_q <= 1'b0;
			low_prio_irq_enable_q <= 1'b0;
		end else if ((phase == rre_pkg::RRE_Q4) && is_irq_ret) begin
			if (i_irq_prio_en && high_prio_irq_enable_q) begin
				low_prio_irq_enable_q <= 1'b1; // RQ2 RQ3
			end else begin
				high_prio_irq_enable_q <= 1'b1; // RQ2 RQ3
			end
		end
	end

	// stack pop and pc load strobes in q4 of first cycle
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_load_q <= 1'b0;
			pop_q <= 1'b0;
		end else begin
			pc_load_q <= (phase == rre_pkg::RRE_Q4) && is_ret; // RQ14
			pop_q <= (phase == rre_pkg::RRE_Q4) && is_ret; // RQ1 RQ7 RQ9
		end
	end

	// program counter from the popped stack top
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= rre_pkg::PC_RST;
		end else if ((phase == rre_pkg::RRE_Q4) && is_ret) begin
			pc_q <= i_stack_top; // RQ1 RQ7 RQ9
		end
	end

	// pc latches copied through, never written here
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			pch_q <= 8'h00;
			pcu_q <= 8'h00;
		end else begin
			pch_q <= i_pc_high_latch; // RQ8
			pcu_q <= i_pc_upper_latch; // RQ8
		end
	end

	// return and pc outputs
	assign o_stack_pop = pop_q;
	assign o_pc = pc_q;
	assign o_pc_load = pc_load_q;

	// architectural state outputs
	assign o_working = working_q;
	assign o_flags = flags_q;
	assign o_bank_select_reg = bsr_q;
	assign o_high_prio_irq_enable = high_prio_irq_enable_q;
	assign o_low_prio_irq_enable = low_prio_irq_enable_q;

	// file bus outputs
	assign o_mem_addr = addr_q;
	assign o_mem_rd = rd_q || ((phase == rre_pkg::RRE_Q2) && is_rot);
	assign o_mem_wr = wr_q;

	// latch copies and no-op flag
	assign o_pc_high_latch = pch_q; // RQ8
	assign o_pc_upper_latch = pcu_q; // RQ8
	assign o_busy = nop_cycle_q;

endmodule : rre_exec

/* rre_exec_properties.sv */
`timescale 1ns/100ps
module rre_exec_properties (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic o_stack_pop,
	input wire logic o_pc_load,
	input wire logic [20:0] o_pc,
	input wire logic [7:0] o_working,
	input wire logic [7:0] o_flags,
	input wire logic o_high_prio_irq_enable,
	input wire logic o_low_prio_irq_enable,
	input wire logic o_mem_rd,
	input wire rre_pkg::rre_mem_wr_t o_mem_wr,
	input wire logic o_busy
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence noop_tail_s;
		o_busy [*4] ##1 !o_busy;
	endsequence
	pop_load_a: assert property (o_stack_pop == o_pc_load) else $error("pop apart");
	pop_busy_a: assert property (o_stack_pop |-> noop_tail_s) else $error("busy len");
	pc_cause_a: assert property ($changed(o_pc) |-> ##[0:1] o_pc_load) else $error("pc moved");
	irq_keep_a: assert property (!$fell(o_high_prio_irq_enable) && !$fell(o_low_prio_irq_enable))
		else $error("enable fell");
	irq_cause_a: assert property ($rose(o_high_prio_irq_enable) || $rose(o_low_prio_irq_enable)
		|-> ##[0:1] o_stack_pop) else $error("enable cause");
	wr_pulse_a: assert property (o_mem_wr.we |=> !o_mem_wr.we [*3]) else $error("we len");
	wr_after_rd_a: assert property (o_mem_wr.we |-> $past(o_mem_rd, 3)) else $error("no rd");
	noop_hold_a: assert property (o_busy && $past(o_busy) |-> $stable(o_flags) && $stable(o_working)
		&& !o_mem_wr.we) else $error("noop moved");
endmodule : rre_exec_properties

bind rre_exec rre_exec_properties chk_u (.*);

/* return_and_rotate_exec_tb.sv */
`timescale 1ns/100ps
module return_and_rotate_exec_tb;
	logic i_mclk = 0, i_reset_n = 0, i_instr_valid = 0, i_ext_set_en = 0, i_irq_prio_en = 0;
	logic [15:0] i_instr = '0;
	logic [20:0] i_stack_top = '0, o_pc, pc = '0;
	logic [7:0] i_fsr2_base = '0, i_mem_rdata = '0, i_working_shadow = '0, i_flags_shadow = '0;
	logic [7:0] i_pc_high_latch = '0, i_pc_upper_latch = '0, o_working, o_flags, w = '0, f = '0;
	logic [7:0] o_pc_high_latch, o_pc_upper_latch, r, wd;
	logic [3:0] i_bank_select_shadow = '0, o_bank_select_reg, b = '0;
	logic o_stack_pop, o_pc_load, o_high_prio_irq_enable, o_low_prio_irq_enable, o_busy;
	logic hi = 0, lo = 0, we = 0, rt = 0;
	logic [11:0] wa, o_mem_addr;
	rre_pkg::rre_mem_wr_t o_mem_wr;
	int error_cnt = 0, cmp_count = 0, pops = 0, ep = 1, cyc = 0;
	rre_exec dut_u (.o_mem_rd(), .*);
	always #2 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc++;
		if (o_stack_pop === 1'b1) pops++;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wrap_up;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic ck(input logic ok);
		cmp_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t output mismatch", $time);
		end
	endtask : ck
	task automatic run(input logic [15:0] x, input int n, input logic v, input logic e);
		i_instr <= x;
		i_instr_valid <= v;
		i_ext_set_en <= e;
		{i_irq_prio_en, i_stack_top, i_working_shadow, i_flags_shadow, i_bank_select_shadow}
			<= 42'({$urandom, $urandom});
		{i_mem_rdata, i_fsr2_base[6:0], i_pc_high_latch, i_pc_upper_latch} <= 31'($urandom);
		@(posedge i_mclk);
		#1;
		ck(o_working === w && o_flags === f && o_bank_select_reg === b);
		ck(o_pc === pc && pops === ep && o_busy === 1'b0);
		ck(o_high_prio_irq_enable === hi && o_low_prio_irq_enable === lo);
		ck(o_mem_wr.we === we && (!we || o_mem_wr.addr === wa && o_mem_wr.data === wd));
		ck(!rt || o_mem_addr === wa);
		ck(o_pc_high_latch === i_pc_high_latch && o_pc_upper_latch === i_pc_upper_latch);
		we = 0;
		rt = 0;
		if (v && (x[15:1] == rre_pkg::RET_IRQ_HI || x[15:1] == rre_pkg::RET_SUB_HI)) begin
			pc = i_stack_top;
			ep++;
			if (x[0]) {w, f, b} = {i_working_shadow, i_flags_shadow, i_bank_select_shadow};
			if (!x[1] && i_irq_prio_en && hi) lo = 1;
			else if (!x[1]) hi = 1;
		end else if (v && x[15:8] == rre_pkg::RET_LIT_HI) begin
			pc = i_stack_top;
			ep++;
			w = x[7:0];
		end else if (v && x[15:10] == rre_pkg::ROT_HI) begin
			r = {i_mem_rdata[6:0], f[0]};
			f[0] = i_mem_rdata[7];
			f[2] = r == 8'h00;
			f[4] = r[7];
			wa = {x[7] ? rre_pkg::ACCESS_HI_BANK : 4'h0, x[7:0]};
			if (x[8]) wa = {b, x[7:0]};
			else if (e && x[7:0] <= rre_pkg::ILO_MAX) wa = {4'h0, 8'(i_fsr2_base + x[7:0])};
			if (!x[9]) w = r;
			else {we, wd} = {1'b1, r};
			rt = 1;
		end
		repeat (n - 1) @(posedge i_mclk);
	endtask : run
	initial begin
		logic [15:0] x;
		void'($urandom(77));
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1;
		repeat (4) @(posedge i_mclk);
		i_instr <= {rre_pkg::RET_SUB_HI, 1'b0};
		i_instr_valid <= 1;
		do begin
			@(posedge i_mclk);
			#1;
		end while (o_stack_pop !== 1'b1);
		repeat (3) @(posedge i_mclk);
		run({rre_pkg::ROT_HI, 2'b10, 8'h5f}, 4, 1, 1);
		run({rre_pkg::ROT_HI, 2'b10, 8'h60}, 4, 1, 1);
		run({rre_pkg::ROT_HI, 2'b10, 8'h80}, 4, 1, 0);
		run({rre_pkg::ROT_HI, 2'b01, 8'h33}, 4, 0, 0);
		run(16'hffff, 4, 1, 0);
		repeat (60) begin
			x = 16'($urandom);
			case ($urandom_range(3))
				0: x[15:1] = rre_pkg::RET_IRQ_HI;
				1: x[15:1] = rre_pkg::RET_SUB_HI;
				2: x[15:8] = rre_pkg::RET_LIT_HI;
				default: x[15:10] = rre_pkg::ROT_HI;
			endcase
			run(x, x[15:10] == rre_pkg::ROT_HI ? 4 : 8, 1, 1'($urandom));
		end
		run(16'hffff, 4, 1, 0);
		wrap_up();
	end
endmodule : return_and_rotate_exec_tb
